// file: pkg/pdcl_regs.vh
`ifndef PDCL_REGS_VH
`define PDCL_REGS_VH
// Command codes in the leading three bits
`define PDCL_CMD_NULL 3'h0
`define PDCL_CMD_MASK 3'h1
`define PDCL_CMD_MODE 3'h2
`define PDCL_CMD_CLR 3'h3
`define PDCL_CMD_DEAD 3'h4
// Word layout
`define PDCL_WORD_W 8
`define PDCL_CMD_HI 7
`define PDCL_CMD_LO 5
`define PDCL_GRP_BIT 4
`define PDCL_SUB_HI 1
// Mode field positions
`define PDCL_MODE_DESAT 3
`define PDCL_MODE_SIMULTANEOUS_DRIVE_MODE 1
`define PDCL_MODE_LOCK 0
// Reset values
`define PDCL_MASK_RST 4'hF
`define PDCL_MODE_RST 4'h0
`define PDCL_DEAD_RST 5'h00
// Pin synchroniser: both supply-ok bits start high, all others low
`define PDCL_SYNC_RST 17'h18000
// Group A flags
`define PDCL_FA_OTEMP 0
`define PDCL_FA_DESAT 1
`define PDCL_FA_LSUV 2
`define PDCL_FA_OCUR 3
// Group B flags
`define PDCL_FB_PHASE 0
`define PDCL_FB_FRAME 1
`define PDCL_FB_WRERR 2
`define PDCL_FB_RESET 3
// Timing: blanking time in ns, per-step deadtime in ns
`define PDCL_BLANK_NS 1000
`define PDCL_DT_STEP_NS 50
`define PDCL_CLK_NS 10
`define PDCL_CNT_W 12
`endif

// file: hw/pdcl_spi_shift.v
`timescale 1ns/1ps
`include "pdcl_regs.vh"
// SPI slave: samples on rising clock edge, shifts out MSB first
module pdcl_spi_shift (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // Synchronised pins
  input wire i_sclk,
  input wire i_cs_b,
  input wire i_mosi,
  // Response word loaded at frame start
  input wire [7:0] i_resp,
  // Frame results
  output reg o_miso_reg,
  output reg o_done_reg,
  output reg o_frame_err_reg,
  output reg o_start_reg,
  output reg [7:0] o_word_reg
);
  reg sclk_d_reg;
  reg cs_d_reg;
  reg [2:0] bit_cnt_reg;
  reg [7:0] tx_reg;
  reg got_reg;
  wire rise = i_sclk & ~sclk_d_reg;
  wire fall = ~i_sclk & sclk_d_reg;
  wire cs_fall = ~i_cs_b & cs_d_reg;
  wire cs_rise = i_cs_b & ~cs_d_reg;

  ////////////////////////////////////////////////////////////////////
  // Shift engine
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
      bit_cnt_reg <= 3'h0;
      tx_reg <= 8'h00;
      got_reg <= 1'b0;
      o_miso_reg <= 1'b0;
      o_done_reg <= 1'b0;
      o_frame_err_reg <= 1'b0;
      o_start_reg <= 1'b0;
      o_word_reg <= 8'h00;
    end else begin
      sclk_d_reg <= i_sclk;
      cs_d_reg <= i_cs_b;
      o_done_reg <= 1'b0;
      o_frame_err_reg <= 1'b0;
      o_start_reg <= cs_fall;
      if (cs_fall) begin
        bit_cnt_reg <= 3'h0;
        tx_reg <= i_resp;
        got_reg <= 1'b0;
        o_miso_reg <= i_resp[`PDCL_WORD_W-1]; // RULE_24
      end else if (!i_cs_b && rise) begin
        o_word_reg <= {o_word_reg[6:0], i_mosi}; // RULE_11
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        got_reg <= 1'b1;
      end else if (!i_cs_b && fall) begin
        tx_reg <= {tx_reg[6:0], tx_reg[`PDCL_WORD_W-1]};
        o_miso_reg <= tx_reg[`PDCL_WORD_W-2]; // RULE_24
      end else if (cs_rise) begin
        o_done_reg <= got_reg & (bit_cnt_reg == 3'h0); // RULE_13
        o_frame_err_reg <= ~got_reg | (bit_cnt_reg != 3'h0); // RULE_13
      end
    end
  end
endmodule // pdcl_spi_shift

// file: hw/pdcl_phase_chk.v
`timescale 1ns/1ps
`include "pdcl_regs.vh"
// One phase: bootstrap gate, deadtime and phase error check
module pdcl_phase_chk (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // Control
  input wire i_enable,
  input wire i_simultaneous_drive_mode,
  input wire [`PDCL_CNT_W-1:0] i_wait_cnt,
  input wire [`PDCL_CNT_W-1:0] i_dt_cnt,
  // Commands and sense
  input wire i_hs_cmd,
  input wire i_ls_cmd,
  input wire i_sense,
  // Results
  output reg o_hs_drv_reg,
  output reg o_ls_drv_reg,
  output reg o_err_reg
);
  reg ls_seen_reg;
  reg hs_d_reg;
  reg ls_d_reg;
  reg [`PDCL_CNT_W-1:0] cnt_reg;
  wire hs_ok = i_hs_cmd & ls_seen_reg;
  wire chg = (hs_ok != hs_d_reg) | (i_ls_cmd != ls_d_reg);
  wire dt_done = i_simultaneous_drive_mode | (cnt_reg >= i_dt_cnt);
  wire hs_err = hs_ok & ~i_sense; // RULE_01
  wire ls_err = i_ls_cmd & i_sense; // RULE_02

  ////////////////////////////////////////////////////////////////////
  // Gate, deadtime and check
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ls_seen_reg <= 1'b0;
      hs_d_reg <= 1'b0;
      ls_d_reg <= 1'b0;
      cnt_reg <= {`PDCL_CNT_W{1'b0}};
      o_hs_drv_reg <= 1'b0;
      o_ls_drv_reg <= 1'b0;
      o_err_reg <= 1'b0;
    end else if (!i_enable) begin
      ls_seen_reg <= 1'b0; // RULE_09
      hs_d_reg <= 1'b0;
      ls_d_reg <= 1'b0;
      cnt_reg <= {`PDCL_CNT_W{1'b0}};
      o_hs_drv_reg <= 1'b0;
      o_ls_drv_reg <= 1'b0;
      o_err_reg <= 1'b0;
    end else begin
      if (i_ls_cmd)
        ls_seen_reg <= 1'b1; // RULE_09
      hs_d_reg <= hs_ok;
      ls_d_reg <= i_ls_cmd;
      if (chg)
        cnt_reg <= {`PDCL_CNT_W{1'b0}};
      else if (cnt_reg != {`PDCL_CNT_W{1'b1}})
        cnt_reg <= cnt_reg + {{(`PDCL_CNT_W-1){1'b0}}, 1'b1};
      o_hs_drv_reg <= hs_ok & (dt_done | o_hs_drv_reg) & ~chg; // RULE_08
      o_ls_drv_reg <= i_ls_cmd & (dt_done | o_ls_drv_reg) & ~chg;
      // Check only after deadtime plus blanking, never in full-on mode
      o_err_reg <= ~i_simultaneous_drive_mode & ~chg & (cnt_reg >= i_wait_cnt) & // RULE_23
        (hs_err | ls_err); // RULE_03
    end
  end
endmodule // pdcl_phase_chk

// file: hw/pdcl_core.v
`timescale 1ns/1ps
`include "pdcl_regs.vh"
// What this block does
// [RULE_01] Flag high-side error if node still low after deadtime plus blanking.
// [RULE_02] Flag low-side error if node still high after deadtime plus blanking.
// [RULE_03] Phase error is OR of sides, flag is OR of three phases.
// [RULE_04] Masked phase flag drives interrupt high until gone and cleared.
// [RULE_05] All gate outputs low on low logic supply, reset, low-side undervoltage.
// [RULE_06] Reset low: sleep, outputs off, all error and SPI state cleared.
// [RULE_07] Either enable low: standby, switches held off, SPI still works.
// [RULE_08] Both enables high: outputs follow inputs, fault detection active.
// [RULE_09] High-side held off until its low-side input pulsed once.
// [RULE_10] Controller should give a long first low-side pulse; unchecked.
// [RULE_11] Eight-bit commands; only last eight bits of a frame count.
// [RULE_12] Three leading bits are command, five trailing bits data.
// [RULE_13] Bit count not multiple of eight raises framing error, discards.
// [RULE_14] First response after reset is status register zero.
// [RULE_15] Status query changes nothing, returns status register chosen by subcommand.
// [RULE_16] Mask command loads selected four-bit group; returns status zero.
// [RULE_17] Changing masks never drops interrupt while enabled faults remain.
// [RULE_18] Mode command sets fault mode, simultaneous drive, lock bit.
// [RULE_19] Clear command clears selected latches; interrupt stays for others.
// [RULE_20] Deadtime command sets deadtime; returns status register zero.
// [RULE_21] Clear acts at chip-select rise, valid frame, unchanged fault only.
// [RULE_22] Lock cleared only by reset; later writes rejected with write error.
// [RULE_23] Simultaneous-drive mode blanks the phase error.
// [RULE_24] Response MSB first while selected; command runs at chip-select rise.
module pdcl_core (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // Supplies and enables
  input wire i_logic_supply_ok,
  input wire i_low_side_supply_ok,
  input wire i_enable_line_one,
  input wire i_enable_line_two,
  // Phase commands and sense, bit per phase
  input wire [2:0] i_high_side_cmd_input,
  input wire [2:0] i_low_side_cmd_input,
  input wire [2:0] i_phase_node_sense,
  // Other fault sources
  input wire i_overtemp,
  input wire i_desat,
  input wire i_overcurrent,
  // SPI pins
  input wire i_sclk,
  input wire i_cs_b,
  input wire i_mosi,
  output reg o_miso,
  // Gate drives and status
  output reg [2:0] o_high_side_drive,
  output reg [2:0] o_low_side_drive,
  output reg o_irq,
  output reg o_phase_error,
  output reg o_desat_mode,
  output reg [4:0] o_deadtime
);
  // Blanking and deadtime step counts derived from the clock period
  localparam [`PDCL_CNT_W-1:0] BLANK_CYC =
    (`PDCL_BLANK_NS + `PDCL_CLK_NS - 1) / `PDCL_CLK_NS;
  localparam [`PDCL_CNT_W-1:0] DT_STEP_CYC =
    (`PDCL_DT_STEP_NS + `PDCL_CLK_NS - 1) / `PDCL_CLK_NS;
  // Modes
  localparam [1:0] ST_SLEEP = 2'h0;
  localparam [1:0] ST_STBY = 2'h1;
  localparam [1:0] ST_ENAB = 2'h2;

  // Two-flop synchronisers for all asynchronous pins
  reg [16:0] s1_reg;
  reg [16:0] s2_reg;
  wire [16:0] raw = {i_logic_supply_ok, i_low_side_supply_ok,
    i_enable_line_one, i_enable_line_two, i_high_side_cmd_input,
    i_low_side_cmd_input, i_phase_node_sense, i_overtemp, i_desat,
    i_overcurrent, i_sclk};
  wire vdd_ok = s2_reg[16];
  wire vls_ok = s2_reg[15];
  wire en1 = s2_reg[14];
  wire en2 = s2_reg[13];
  wire [2:0] hs_in = s2_reg[12:10];
  wire [2:0] ls_in = s2_reg[9:7];
  wire [2:0] sense = s2_reg[6:4];
  wire f_otemp = s2_reg[3];
  wire f_desat = s2_reg[2];
  wire f_ocur = s2_reg[1];
  wire sclk_s = s2_reg[0];
  // Chip select and data share one synchroniser pair
  reg [1:0] cs1_reg;
  reg [1:0] cs2_reg;
  wire cs_s = cs2_reg[0];
  wire mosi_s = cs2_reg[1];

  ////////////////////////////////////////////////////////////////////
  // Synchronisers
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_reg <= `PDCL_SYNC_RST; // No false undervoltage after release
      s2_reg <= `PDCL_SYNC_RST;
      cs1_reg <= 2'h1;
      cs2_reg <= 2'h1;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      cs1_reg <= {i_mosi, i_cs_b};
      cs2_reg <= cs1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Mode state
  reg [1:0] mode_reg;
  reg [1:0] mode_next;
  // Mode decode from the enables
  always @* begin
    case ({en1, en2})
      2'h3: mode_next = ST_ENAB; // RULE_08
      default: mode_next = ST_STBY; // RULE_07
    endcase
  end
  // Mode register, sleep while reset is held
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b)
      mode_reg <= ST_SLEEP; // RULE_06
    else
      mode_reg <= mode_next;
  end
  // Hold-off: a missing supply or any mode but enable forces drives off
  wire in_enable = (mode_reg == ST_ENAB); // RULE_08
  wire supplies_ok = vdd_ok & vls_ok; // RULE_05
  wire drive_ok = in_enable & supplies_ok; // RULE_05

  ////////////////////////////////////////////////////////////////////
  // Configuration registers
  reg [3:0] mask_a_reg;
  reg [3:0] mask_b_reg;
  reg [3:0] mode_cfg_reg;
  reg [4:0] dead_reg;
  reg [3:0] lat_a_reg;
  reg [3:0] lat_b_reg;
  reg [3:0] snap_a_reg;
  reg [3:0] snap_b_reg;
  // Mode bits used by the phase channels and the write gate
  wire simultaneous_drive_mode = mode_cfg_reg[`PDCL_MODE_SIMULTANEOUS_DRIVE_MODE];
  wire locked = mode_cfg_reg[`PDCL_MODE_LOCK];
  // Deadtime in cycles, and the wait before a phase is checked
  wire [`PDCL_CNT_W-1:0] dt_cnt =
    DT_STEP_CYC * {{(`PDCL_CNT_W-5){1'b0}}, dead_reg};
  wire [`PDCL_CNT_W-1:0] wait_cnt = dt_cnt + BLANK_CYC;

  ////////////////////////////////////////////////////////////////////
  // Phase channels
  wire [2:0] hs_drv;
  wire [2:0] ls_drv;
  wire [2:0] ph_err;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_phase
      pdcl_phase_chk u_phase (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_enable(drive_ok),
        .i_simultaneous_drive_mode(simultaneous_drive_mode),
        .i_wait_cnt(wait_cnt),
        .i_dt_cnt(dt_cnt),
        .i_hs_cmd(hs_in[g]),
        .i_ls_cmd(ls_in[g]),
        .i_sense(sense[g]),
        .o_hs_drv_reg(hs_drv[g]),
        .o_ls_drv_reg(ls_drv[g]),
        .o_err_reg(ph_err[g])
      );
    end
  endgenerate
  // Phase error flag across all three phases
  wire phase_flag = |ph_err; // RULE_03

  ////////////////////////////////////////////////////////////////////
  // SPI shifter
  wire spi_miso;
  wire spi_done;
  wire spi_ferr;
  wire spi_start;
  wire [7:0] spi_word;
  // Response word offered at the next frame start
  reg [1:0] sel_reg;
  reg [7:0] resp;
  pdcl_spi_shift u_spi (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_sclk(sclk_s),
    .i_cs_b(cs_s),
    .i_mosi(mosi_s),
    .i_resp(resp),
    .o_miso_reg(spi_miso),
    .o_done_reg(spi_done),
    .o_frame_err_reg(spi_ferr),
    .o_start_reg(spi_start),
    .o_word_reg(spi_word)
  );

  // Status word selection
  function [7:0] pdcl_status;
    input [1:0] sel;
    input [3:0] la;
    input [3:0] lb;
    input [3:0] ma;
    input [3:0] mb;
    input [3:0] md;
    input [4:0] dt;
    begin
      case (sel)
        2'h0: pdcl_status = {lb, la};
        2'h1: pdcl_status = {mb, ma};
        2'h2: pdcl_status = {4'h0, md};
        2'h3: pdcl_status = {3'h0, dt};
        default: pdcl_status = 8'h00;
      endcase
    end
  endfunction
  // Selected status word for the shifter
  always @* begin
    resp = pdcl_status(sel_reg, lat_a_reg, lat_b_reg, mask_a_reg,
      mask_b_reg, mode_cfg_reg, dead_reg); // RULE_15
  end

  ////////////////////////////////////////////////////////////////////
  // Command decode and fault latches
  wire [2:0] cmd = spi_word[`PDCL_CMD_HI:`PDCL_CMD_LO]; // RULE_12
  wire grp = spi_word[`PDCL_GRP_BIT];
  wire [3:0] nib = spi_word[3:0];
  // Decodes for null and clear, one write strobe for mask, mode and deadtime
  wire is_null = (cmd == `PDCL_CMD_NULL);
  wire is_clr = (cmd == `PDCL_CMD_CLR);
  wire is_write = spi_done & ~is_null & ~is_clr & (cmd <= `PDCL_CMD_DEAD);
  wire wr_ok = is_write & ~locked; // RULE_22
  wire wr_err = is_write & locked; // RULE_22
  // Reset event: one pulse in the first cycle after release
  reg rst_evt_reg;
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b)
      rst_evt_reg <= 1'b1;
    else
      rst_evt_reg <= 1'b0;
  end
  // Fault events per group
  wire [3:0] ev_a;
  wire [3:0] ev_b;
  assign ev_a[`PDCL_FA_OTEMP] = f_otemp & drive_ok;
  assign ev_a[`PDCL_FA_DESAT] = f_desat & drive_ok;
  assign ev_a[`PDCL_FA_LSUV] = ~vls_ok & (mode_reg != ST_SLEEP);
  assign ev_a[`PDCL_FA_OCUR] = f_ocur & drive_ok;
  assign ev_b[`PDCL_FB_PHASE] = phase_flag;
  assign ev_b[`PDCL_FB_FRAME] = spi_ferr;
  assign ev_b[`PDCL_FB_WRERR] = wr_err;
  assign ev_b[`PDCL_FB_RESET] = rst_evt_reg; // RULE_04
  // Clear bits for one group, sparing bits that moved in the frame
  function [3:0] pdcl_clr_bits;
    input sel;
    input [3:0] req;
    input [3:0] now;
    input [3:0] snap;
    begin
      if (sel)
        pdcl_clr_bits = req & ~(now ^ snap); // RULE_21
      else
        pdcl_clr_bits = 4'h0;
    end
  endfunction
  wire clr_now = spi_done & is_clr; // RULE_21
  wire [3:0] clr_a = pdcl_clr_bits(clr_now & ~grp, nib, lat_a_reg,
    snap_a_reg);
  wire [3:0] clr_b = pdcl_clr_bits(clr_now & grp, nib, lat_b_reg,
    snap_b_reg);

  // Fault latches, response select and configuration writes
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mask_a_reg <= `PDCL_MASK_RST; // RULE_06
      mask_b_reg <= `PDCL_MASK_RST;
      mode_cfg_reg <= `PDCL_MODE_RST;
      dead_reg <= `PDCL_DEAD_RST;
      lat_a_reg <= 4'h0;
      lat_b_reg <= 4'h0;
      snap_a_reg <= 4'h0;
      snap_b_reg <= 4'h0;
      sel_reg <= 2'h0; // RULE_14
    end else begin
      // Set wins over clear
      lat_a_reg <= (lat_a_reg & ~clr_a) | ev_a; // RULE_19
      lat_b_reg <= (lat_b_reg & ~clr_b) | ev_b; // RULE_04
      if (spi_start) begin
        snap_a_reg <= lat_a_reg;
        snap_b_reg <= lat_b_reg;
      end
      if (spi_done) begin
        if (cmd == `PDCL_CMD_NULL)
          sel_reg <= spi_word[`PDCL_SUB_HI:0]; // RULE_15
        else
          sel_reg <= 2'h0; // RULE_16
      end
      if (wr_ok) begin
        case (cmd)
          `PDCL_CMD_MASK: begin
            if (grp)
              mask_b_reg <= nib; // RULE_16
            else
              mask_a_reg <= nib;
          end
          `PDCL_CMD_MODE: begin
            mode_cfg_reg <= {nib[`PDCL_MODE_DESAT], 1'b0, // RULE_18
              nib[`PDCL_MODE_SIMULTANEOUS_DRIVE_MODE], nib[`PDCL_MODE_LOCK]};
          end
          `PDCL_CMD_DEAD: dead_reg <= spi_word[4:0]; // RULE_20
          default: dead_reg <= dead_reg;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Registered outputs
  wire irq_a = |(lat_a_reg & mask_a_reg);
  wire irq_b = |(lat_b_reg & mask_b_reg);
  // Output flops
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_miso <= 1'b0;
      o_high_side_drive <= 3'h0; // RULE_05
      o_low_side_drive <= 3'h0;
      o_irq <= 1'b0;
      o_phase_error <= 1'b0;
      o_desat_mode <= 1'b0;
      o_deadtime <= 5'h00;
    end else begin
      o_miso <= spi_miso & ~cs_s; // RULE_24
      o_high_side_drive <= drive_ok ? hs_drv : 3'h0; // RULE_07
      o_low_side_drive <= drive_ok ? ls_drv : 3'h0;
      o_irq <= irq_a | irq_b; // RULE_17
      o_phase_error <= lat_b_reg[`PDCL_FB_PHASE];
      o_desat_mode <= mode_cfg_reg[`PDCL_MODE_DESAT];
      o_deadtime <= dead_reg;
    end
  end
endmodule // pdcl_core

// file: tb/pdcl_mcu_model.sv
`timescale 1ns/1ps
// Controller side of the serial port, mode 0 master
module pdcl_mcu_model (
  // Clock
  input wire logic i_clk,
  // Serial pins
  input wire logic i_miso,
  output logic o_sclk,
  output logic o_cs_b,
  output logic o_mosi
);
  // Idle levels
  initial begin
    o_sclk = 1'b0;
    o_cs_b = 1'b1;
    o_mosi = 1'b1;
  end
  // Shift n bits of d MSB first, keep last eight returned bits
  task xfer(input logic [15:0] d, input int n, output logic [7:0] r);
    int k;
    r = 8'h00;
    @(negedge i_clk);
    o_cs_b = 1'b0;
    repeat (8) @(negedge i_clk);
    for (k = n - 1; k >= 0; k--) begin
      o_mosi = d[k];
      repeat (4) @(negedge i_clk);
      o_sclk = 1'b1;
      repeat (4) @(negedge i_clk);
      r = {r[6:0], i_miso};
      o_sclk = 1'b0;
    end
    repeat (4) @(negedge i_clk);
    o_cs_b = 1'b1;
    o_mosi = ~o_mosi; // No stale data once released
    repeat (12) @(negedge i_clk);
  endtask
endmodule // pdcl_mcu_model

// file: tb/pdcl_core_assertions.sv
`timescale 1ns/1ps
// Port-level checks on the core
module pdcl_core_assertions (
  // Clock and reset
  input logic i_clk,
  input logic i_rst_b,
  // Watched pins
  input logic i_logic_supply_ok,
  input logic i_low_side_supply_ok,
  input logic i_enable_line_one,
  input logic i_enable_line_two,
  input logic [2:0] i_low_side_cmd_input,
  input logic i_cs_b,
  input logic o_miso,
  input logic [2:0] o_high_side_drive,
  input logic [2:0] o_low_side_drive,
  input logic o_irq,
  input logic o_phase_error,
  input logic [4:0] o_deadtime
);
  logic [2:0] seen_reg;
  wire en = i_enable_line_one & i_enable_line_two;
  wire off = (o_high_side_drive | o_low_side_drive) == 3'h0;
  // Low-side command seen since enable
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b)
      seen_reg <= 3'h0;
    else if (!en)
      seen_reg <= 3'h0;
    else
      seen_reg <= seen_reg | i_low_side_cmd_input;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  a_reset_outputs_low: assert property ($rose(i_rst_b) |->
    off && !o_phase_error && !o_miso) else $error("not quiet at reset");
  a_reset_irq_up: assert property ($rose(i_rst_b) |-> ##[1:4] o_irq)
    else $error("no reset irq");
  a_standby_drive_off: assert property ((!en)[*6] |-> off)
    else $error("drive in standby");
  a_supply_drive_off: assert property (
    (!i_low_side_supply_ok || !i_logic_supply_ok)[*6] |-> off)
    else $error("drive on low supply");
  a_miso_idle_low: assert property (i_cs_b[*6] |-> !o_miso)
    else $error("miso busy when idle");
  a_hs_after_ls: assert property (
    (o_high_side_drive & ~$past(o_high_side_drive) & ~seen_reg) == 3'h0)
    else $error("high side before low side");
  a_dt_at_cs: assert property (!$stable(o_deadtime) |->
    $past(i_cs_b, 2)) else $error("deadtime moved in frame");
  a_perr_clear_cs: assert property ($fell(o_phase_error) |->
    $past(i_cs_b, 2)) else $error("phase flag fell in frame");
  a_irq_hold_cs: assert property ($fell(o_irq) |->
    $past(i_cs_b, 2)) else $error("irq fell without command");
endmodule // pdcl_core_assertions

bind pdcl_core pdcl_core_assertions u_chk (.*);

// file: tb/pdcl_core_bench.sv
`timescale 1ns/1ps
module pdcl_core_bench;
  // Design pins and bench state
  logic i_clk = 1'b0, i_rst_b = 1'b0, i_logic_supply_ok = 1'b1;
  logic i_low_side_supply_ok = 1'b1, i_overtemp = 1'b0, i_desat = 1'b0;
  logic i_overcurrent = 1'b0, i_enable_line_one = 1'b0;
  logic i_enable_line_two = 1'b1, i_sclk, i_cs_b, i_mosi;
  logic [2:0] i_high_side_cmd_input = 3'h0, i_low_side_cmd_input = 3'h0;
  logic [2:0] i_phase_node_sense = 3'h0, o_high_side_drive;
  logic [2:0] o_low_side_drive;
  logic o_miso, o_irq, o_phase_error, o_desat_mode;
  logic [4:0] o_deadtime;
  logic [7:0] rsp;
  int fail_count = 0, num_checks = 0;
  // Design and controller
  pdcl_core DUT (.*);
  pdcl_mcu_model u_mcu (
    .i_clk(i_clk),
    .i_miso(o_miso),
    .o_sclk(i_sclk),
    .o_cs_b(i_cs_b),
    .o_mosi(i_mosi)
  );
  // Clock
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  // Wait falling edges
  task wt(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // Compare and count
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One command frame, code in the top three bits
  task cmd(input logic [7:0] c);
    u_mcu.xfer({8'h00, c}, 8, rsp);
  endtask
  // Phase commands and sense, then settle
  task ph(input logic [2:0] hs, ls, sn, input int n);
    i_high_side_cmd_input = hs;
    i_low_side_cmd_input = ls;
    i_phase_node_sense = sn;
    wt(n);
  endtask
  // Both drive buses in one byte
  function automatic logic [7:0] drv();
    return {2'b00, o_high_side_drive, o_low_side_drive};
  endfunction
  // Verdict
  task results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge i_clk);
    fail_count++;
    results();
  end
  // Main sequence
  initial begin
    wt(16);
    i_rst_b = 1'b1;
    wt(10);
    chk("irq", 8'h01, 8'(o_irq));
    cmd(8'h01);
    chk("first", 8'h80, rsp);
    cmd(8'h25);
    chk("status1", 8'hFF, rsp);
    chk("irq mask", 8'h01, 8'(o_irq));
    cmd(8'h78);
    chk("mask resp", 8'h80, rsp);
    chk("irq clr", 8'h00, 8'(o_irq));
    cmd(8'h01);
    chk("clr resp", 8'h00, rsp);
    cmd(8'h00);
    chk("masks", 8'hF5, rsp);
    $display("test reset and masks done");
    u_mcu.xfer(16'h0003, 5, rsp);
    chk("irq frame", 8'h01, 8'(o_irq));
    cmd(8'h00);
    cmd(8'h00);
    chk("frame flag", 8'h20, rsp);
    u_mcu.xfer(16'h2072, 16, rsp);
    chk("irq daisy", 8'h00, 8'(o_irq));
    cmd(8'h01);
    cmd(8'h00);
    chk("mask kept", 8'hF5, rsp);
    $display("test framing done");
    cmd(8'h88);
    cmd(8'h49);
    chk("deadtime", 8'h08, 8'(o_deadtime));
    chk("desat", 8'h01, 8'(o_desat_mode));
    cmd(8'h81);
    chk("locked dt", 8'h08, 8'(o_deadtime));
    cmd(8'h00);
    chk("write err", 8'h40, rsp);
    cmd(8'h74);
    chk("irq werr", 8'h00, 8'(o_irq));
    $display("test config done");
    ph(3'h7, 3'h7, 3'h7, 20);
    chk("standby", 8'h00, drv());
    i_enable_line_one = 1'b1;
    ph(3'h7, 3'h0, 3'h7, 300);
    chk("hs locked", 8'h00, drv());
    ph(3'h0, 3'h7, 3'h0, 5000);
    chk("ls on", 8'h07, drv());
    ph(3'h7, 3'h0, 3'h7, 300);
    chk("hs on", 8'h38, drv());
    chk("no perr", 8'h00, 8'(o_phase_error));
    ph(3'h7, 3'h0, 3'h6, 300);
    chk("hs perr", 8'h01, 8'(o_phase_error));
    ph(3'h7, 3'h0, 3'h7, 20);
    chk("irq held", 8'h01, 8'(o_irq));
    cmd(8'h71);
    chk("perr clr", 8'h00, 8'(o_phase_error));
    ph(3'h0, 3'h7, 3'h4, 300);
    chk("ls perr", 8'h01, 8'(o_phase_error));
    $display("test drives done");
    i_low_side_supply_ok = 1'b0;
    wt(10);
    chk("uv off", 8'h00, drv());
    i_low_side_supply_ok = 1'b1;
    i_rst_b = 1'b0;
    wt(3);
    chk("sleep drv", 8'h00, drv());
    chk("sleep flags", 8'h00, 8'({o_irq, o_phase_error, o_miso}));
    i_rst_b = 1'b1;
    wt(10);
    chk("dt reset", 8'h00, 8'(o_deadtime));
    cmd(8'h88);
    chk("unlocked", 8'h08, 8'(o_deadtime));
    cmd(8'h42);
    cmd(8'h79);
    wt(300);
    chk("simultaneous_drive_mode perr", 8'h00, 8'(o_phase_error));
    chk("simultaneous_drive_mode irq", 8'h00, 8'(o_irq));
    i_overtemp = 1'b1;
    i_desat = 1'b1;
    i_overcurrent = 1'b1;
    wt(10);
    chk("fault irq", 8'h01, 8'(o_irq));
    cmd(8'h02);
    chk("faults", 8'h0B, rsp);
    cmd(8'h03);
    chk("status2", 8'h02, rsp);
    cmd(8'h00);
    chk("status3", 8'h08, rsp);
    $display("test modes done");
    $display("test sleep done");
    results();
  end
endmodule // pdcl_core_bench
